// ### src/udpl_link.sv
// usb device link power and enumeration control
`timescale 1ns/1ps
`include "udpl_map.svh"
// Notes on behaviour
// R1 - acts only as high-speed device at 480 Mb/s, never as host
// R2 - interface held disabled unless bus supply sense reports valid supply
// R3 - full profile offers seven functions, usable concurrently
// R4 - enumerate first with temporary identity, full identity after about 5 s
// R5 - host sends no commands under temporary identity
// R6 - with power saving on, suspend after standard bus idle period
// R7 - suspend also when the upstream hub port is disabled
// R8 - address and configuration kept while suspended
// R9 - bus activity on the data lines ends suspend
// R10 - attached and not suspended forces active mode
// R11 - device may signal remote wake-up; host then resumes bus
// R12 - power saving setting still steers serial port enabling
// R13 - suspend after 3 ms idle; remote wake-up off until host enables it
module udpl_link #(
  // temporary identity time in cycles; benches may shorten it
  parameter int REENUM_CYC = `UDPL_REENUM_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_supply_sense,
  input wire logic bus_activity,
  input wire logic hub_port_enabled,
  input wire logic [1:0] power_saving_setting,
  input wire logic uart_idle_ok,
  input wire logic remote_wake_req,
  input wire logic remote_wake_feature_set,
  input wire logic remote_wake_feature_clr,
  input wire logic addr_load,
  input wire logic [6:0] addr_in,
  input wire logic cfg_load,
  input wire logic [7:0] cfg_in,
  output logic usb_enable,
  output logic high_speed_mode,
  output logic host_role,
  output logic identity_full,
  output logic [3:0] function_count,
  output logic reenumerate,
  output logic suspended,
  output logic force_active,
  output logic uart_enable,
  output logic resume_drive,
  output logic [6:0] dev_addr,
  output logic [7:0] dev_cfg
);
  typedef struct packed {
    udpl_pkg::udpl_state_t st;
    logic [`UDPL_CNT_W-1:0] cnt;
    logic [`UDPL_CNT_W-1:0] idle;
    logic wake_en;
    logic [6:0] addr;
    logic [7:0] cfg;
    logic usb_en;
    logic id_full;
    logic [3:0] nfunc;
    logic reenum;
    logic susp;
    logic act;
    logic uart_en;
    logic resume;
  } udpl_link_t;
  udpl_link_t s_q;
  udpl_link_t s_d;
  logic [3:0] pin_s;
  logic vbus_ok;
  logic bus_act;
  logic port_en;
  logic wake_rq;
  logic psv_on;

  // pin inputs pass two flip-flops first
  udpl_sync #(.W(4)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({bus_supply_sense, bus_activity, hub_port_enabled, remote_wake_req}),
    .q(pin_s)
  );
  assign vbus_ok = pin_s[3];
  assign bus_act = pin_s[2];
  assign port_en = pin_s[1];
  assign wake_rq = pin_s[0];
  assign psv_on = (power_saving_setting != `UDPL_PSV_OFF);

  // state machine and counters
  always_comb begin
    s_d = s_q;
    s_d.reenum = 1'b0;
    // remote wake enable: set wins over clear
    if (remote_wake_feature_set) begin
      s_d.wake_en = 1'b1; // [R13]
    end else if (remote_wake_feature_clr) begin
      s_d.wake_en = 1'b0;
    end
    // device state loads; kept across suspend
    if (addr_load) begin
      s_d.addr = addr_in; // [R8]
    end
    if (cfg_load) begin
      s_d.cfg = cfg_in; // [R8]
    end
    // idle counter runs while no traffic
    if (bus_act) begin
      s_d.idle = '0;
    end else if (s_q.idle != `UDPL_CNT_W'(`UDPL_IDLE_CYC)) begin
      s_d.idle = s_q.idle + `UDPL_CNT_W'(1);
    end
    case (s_q.st)
      udpl_pkg::UDPL_ST_OFF: begin
        s_d.cnt = '0;
        if (vbus_ok) begin
          s_d.st = udpl_pkg::UDPL_ST_TEMP;
          s_d.id_full = `UDPL_ID_TEMP; // [R4]
          s_d.nfunc = `UDPL_FUNC_NONE; // [R5]
        end
      end
      udpl_pkg::UDPL_ST_TEMP: begin
        if (s_q.cnt == `UDPL_CNT_W'(REENUM_CYC - 1)) begin
          s_d.st = udpl_pkg::UDPL_ST_ACTIVE;
          s_d.id_full = `UDPL_ID_FULL; // [R4]
          s_d.nfunc = `UDPL_FUNC_FULL; // [R3]
          s_d.reenum = 1'b1;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + `UDPL_CNT_W'(1);
        end
      end
      udpl_pkg::UDPL_ST_ACTIVE: begin
        if (!port_en) begin
          s_d.st = udpl_pkg::UDPL_ST_SUSP; // [R7]
        end else if (psv_on && !bus_act &&
                     s_q.idle == `UDPL_CNT_W'(`UDPL_IDLE_CYC)) begin
          s_d.st = udpl_pkg::UDPL_ST_SUSP; // [R6] [R13]
        end
      end
      udpl_pkg::UDPL_ST_SUSP: begin
        s_d.cnt = '0;
        if (bus_act && port_en) begin
          s_d.st = udpl_pkg::UDPL_ST_ACTIVE; // [R9]
        end else if (wake_rq && s_q.wake_en) begin
          s_d.st = udpl_pkg::UDPL_ST_WAKE; // [R11]
        end
      end
      udpl_pkg::UDPL_ST_WAKE: begin
        // drive resume signalling for a fixed time
        if (s_q.cnt == `UDPL_CNT_W'(`UDPL_WAKE_CYC - 1)) begin
          s_d.st = udpl_pkg::UDPL_ST_SUSP;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + `UDPL_CNT_W'(1);
        end
      end
      default: begin
        s_d.st = udpl_pkg::UDPL_ST_OFF;
      end
    endcase
    // supply loss disables the interface from any state
    if (!vbus_ok) begin
      s_d.st = udpl_pkg::UDPL_ST_OFF; // [R2]
      s_d.id_full = `UDPL_ID_TEMP;
      s_d.nfunc = `UDPL_FUNC_NONE;
      s_d.addr = '0;
      s_d.cfg = '0;
      s_d.wake_en = 1'b0;
    end
    s_d.usb_en = (s_d.st != udpl_pkg::UDPL_ST_OFF); // [R2]
    s_d.susp = (s_d.st == udpl_pkg::UDPL_ST_SUSP);
    s_d.resume = (s_d.st == udpl_pkg::UDPL_ST_WAKE); // [R11]
    // attached and awake keeps module active
    s_d.act = s_d.usb_en && !s_d.susp; // [R10]
    // serial port still follows its own setting and idle
    s_d.uart_en = !psv_on || !uart_idle_ok; // [R10] [R12]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= udpl_pkg::UDPL_ST_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign usb_enable = s_q.usb_en;
  assign high_speed_mode = s_q.usb_en; // [R1]
  assign host_role = s_q.resume & ~s_q.resume; // [R1] device only
  assign identity_full = s_q.id_full;
  assign function_count = s_q.nfunc;
  assign reenumerate = s_q.reenum;
  assign suspended = s_q.susp;
  assign force_active = s_q.act;
  assign uart_enable = s_q.uart_en;
  assign resume_drive = s_q.resume;
  assign dev_addr = s_q.addr;
  assign dev_cfg = s_q.cfg;
endmodule : udpl_link

// ### src/udpl_map.svh
// constant map for the usb device power link block
`ifndef UDPL_MAP_SVH
`define UDPL_MAP_SVH
// 20 MHz clock, period in ns
`define UDPL_CLK_PERIOD_NS 50
// bus idle time before suspend, in us
`define UDPL_IDLE_US 3000
`define UDPL_IDLE_CYC ((`UDPL_IDLE_US * 1000) / `UDPL_CLK_PERIOD_NS)
// delay before re-enumerating with the full identity, in ms
`define UDPL_REENUM_MS 5000
// ms to cycles: keep the product inside 32 bits
`define UDPL_REENUM_CYC (`UDPL_REENUM_MS * (1000000 / `UDPL_CLK_PERIOD_NS))
// count width covers the longest delay
`define UDPL_CNT_W 27
// function count of the full profile
`define UDPL_FUNC_FULL 4'h7
`define UDPL_FUNC_NONE 4'h0
// power saving setting codes
`define UDPL_PSV_OFF 2'h0
`define UDPL_PSV_W 2
// identity select codes
`define UDPL_ID_TEMP 1'b0
`define UDPL_ID_FULL 1'b1
// resume signalling length in us (1 ms)
`define UDPL_WAKE_US 1000
`define UDPL_WAKE_CYC ((`UDPL_WAKE_US * 1000) / `UDPL_CLK_PERIOD_NS)
`endif

// ### src/udpl_pkg.sv
// types for the usb device power link block
package udpl_pkg;
  typedef enum logic [2:0] {
    UDPL_ST_OFF = 3'h0,
    UDPL_ST_TEMP = 3'h1,
    UDPL_ST_ACTIVE = 3'h3,
    UDPL_ST_SUSP = 3'h2,
    UDPL_ST_WAKE = 3'h6
  } udpl_state_t;
endpackage : udpl_pkg

// ### src/udpl_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module udpl_sync #(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } udpl_sync_t;
  udpl_sync_t r_q;
  udpl_sync_t r_d;

  // first stage feeds only the second
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule : udpl_sync

// ### sim/udpl_link_sva.sv
// port assertions for the usb device power link block
`timescale 1ns/1ps
module udpl_link_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_supply_sense,
  input wire logic hub_port_enabled,
  input wire logic usb_enable,
  input wire logic high_speed_mode,
  input wire logic host_role,
  input wire logic identity_full,
  input wire logic [3:0] function_count,
  input wire logic suspended,
  input wire logic force_active,
  input wire logic resume_drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  no_host_a: assert property (!host_role) else $error("host role");
  hs_mode_a: assert property (high_speed_mode == usb_enable)
    else $error("speed mode");
  supply_off_a: assert property (!bus_supply_sense |-> ##3 !usb_enable)
    else $error("enabled without supply");
  supply_on_a: assert property ($rose(bus_supply_sense) ##1
    bus_supply_sense[*2] |=> usb_enable) else $error("enable late");
  temp_none_a: assert property (!identity_full |-> function_count == 4'h0)
    else $error("functions under temporary identity");
  active_a: assert property (force_active == (usb_enable && !suspended))
    else $error("active mode");
  port_susp_a: assert property ($fell(hub_port_enabled) && force_active ##1
    !hub_port_enabled && bus_supply_sense |-> ##2 suspended)
    else $error("no selective suspend");
  wake_susp_a: assert property ($rose(resume_drive) |-> $past(suspended))
    else $error("wake outside suspend");
endmodule : udpl_link_chk
bind udpl_link udpl_link_chk i_udpl_link_chk (.clock, .rst_n,
  .bus_supply_sense, .hub_port_enabled, .usb_enable, .high_speed_mode,
  .host_role, .identity_full, .function_count, .suspended, .force_active,
  .resume_drive);

// ### sim/udpl_host.sv
// host controller model driving bus traffic
`timescale 1ns/1ps
module udpl_host #(
  parameter int LAG = 3
) (
  input wire logic clock,
  input wire logic traffic,
  input wire logic resume_drive,
  output logic bus_activity
);
  int n = 0;
  // resume the bus a little after the wake signal ends
  always_ff @(posedge clock) begin
    n <= $fell(resume_drive) ? LAG : (n > 0 ? n - 1 : 0);
  end
  assign bus_activity = traffic || (n > 0 && n < 3);
endmodule : udpl_host

// ### sim/udpl_link_tb_top.sv
// self-checking bench for the usb device power link block
`timescale 1ns/1ps
module udpl_link_tb_top;
  logic clock = 0, rst_n = 0, bus_supply_sense = 0, hub_port_enabled = 1;
  logic traffic = 0, remote_wake_req = 0, remote_wake_feature_set = 0;
  logic addr_load = 0, bus_activity, usb_enable, suspended, resume_drive;
  logic force_active, uart_enable, high_speed_mode, host_role;
  logic identity_full;
  logic [1:0] power_saving_setting = 2'h0;
  logic [3:0] function_count;
  logic [6:0] dev_addr;
  int errors = 0, total_checks = 0;
  // 20 MHz clock
  always #25 clock = ~clock;
  udpl_host i_udpl_host (.clock, .traffic, .resume_drive, .bus_activity);
  udpl_link #(.REENUM_CYC(2000)) i_udpl_link (.clock, .rst_n,
    .bus_supply_sense, .bus_activity,
    .hub_port_enabled, .power_saving_setting, .uart_idle_ok(1'b1),
    .remote_wake_req, .remote_wake_feature_set,
    .remote_wake_feature_clr(1'b0), .addr_load, .addr_in(7'h2A),
    .cfg_load(1'b0), .cfg_in(8'h00), .usb_enable, .high_speed_mode,
    .host_role, .identity_full, .function_count, .reenumerate(),
    .suspended, .force_active, .uart_enable, .resume_drive, .dev_addr,
    .dev_cfg());
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wt(ref logic s, input logic v, input int n);
    repeat (n) if (s !== v) cyc(1);
    chk(s, v);
  endtask : wt
  // attach with temporary identity, then serial port power saving
  task automatic t_attach;
    chk({host_role, usb_enable, uart_enable}, 8'h01);
    @(posedge clock) bus_supply_sense <= 1;
    cyc(2);
    chk(usb_enable, 0);
    cyc(1);
    chk({usb_enable, high_speed_mode, function_count}, 8'h30);
    @(posedge clock) power_saving_setting <= 2'h1;
    cyc(2);
    chk({uart_enable, force_active}, 8'h01);
    wt(identity_full, 1, 2100);
    chk(function_count, 8'h07);
  endtask : t_attach
  // address load, then hub port disable
  task automatic t_port;
    @(posedge clock) addr_load <= 1;
    @(posedge clock) begin
      addr_load <= 0;
      hub_port_enabled <= 0;
    end
    cyc(2);
    chk(suspended, 0);
    cyc(1);
    chk({suspended, dev_addr}, 8'hAA);
  endtask : t_port
  // wake refused until enabled, then signalled and resumed
  task automatic t_wake;
    @(posedge clock) remote_wake_req <= 1;
    cyc(8);
    chk(resume_drive, 0);
    @(posedge clock) remote_wake_req <= 0;
    @(posedge clock) remote_wake_feature_set <= 1;
    @(posedge clock) remote_wake_feature_set <= 0;
    @(posedge clock) remote_wake_req <= 1;
    wt(resume_drive, 1, 8);
    @(posedge clock) begin
      remote_wake_req <= 0;
      hub_port_enabled <= 1;
    end
    wt(resume_drive, 0, 20010);
    wt(suspended, 0, 30);
    chk(dev_addr, 8'h2A);
  endtask : t_wake
  // idle bus suspends after 3 ms, then supply loss
  task automatic t_idle;
    cyc(59990);
    chk(suspended, 0);
    wt(suspended, 1, 30);
    @(posedge clock) bus_supply_sense <= 0;
    cyc(3);
    chk({usb_enable, dev_addr}, 8'h00);
  endtask : t_idle
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1;
    cyc(2);
    t_attach();
    t_port();
    t_wake();
    t_idle();
    print_verdict();
  end
  // watchdog
  initial begin
    #4800000;
    errors++;
    print_verdict();
  end
endmodule : udpl_link_tb_top
